// ---- logic/drop_stats_pkg.sv ----
// Purpose: shared constants and types for the drop statistics block
// Assumes: registers are word wide, byte address is four times the index
// Notes:   field positions and reason codes of the pending status word
package drop_stats_pkg;

  // register indexes, byte address is index times four
  localparam logic [13:0] IDX_CNT0    = 14'h1c16;
  localparam logic [13:0] IDX_CNT1    = 14'h1c17;
  localparam logic [13:0] IDX_CNT2    = 14'h1c18;
  localparam logic [13:0] IDX_MASK    = 14'h1c20;
  localparam logic [13:0] IDX_PEND    = 14'h1c21;

  // reset values and counter top
  localparam logic [31:0] CNT_RESET   = 32'h0000_0000;
  localparam logic [31:0] CNT_MAX     = 32'hffff_ffff;
  localparam logic        MASK_RESET  = 1'b1;

  // mask and pending word field positions
  localparam int          MASK_BIT    = 0;
  localparam int          A_VALID_BIT = 0;
  localparam int          A_PORT_LSB  = 1;
  localparam int          A_RSN_LSB   = 3;
  localparam int          B_PEND_BIT  = 7;
  localparam int          B_PORT_LSB  = 8;
  localparam int          B_RSN_LSB   = 10;

  // source port codes
  localparam logic [1:0]  PORT_0      = 2'h0;
  localparam logic [1:0]  PORT_1      = 2'h1;
  localparam logic [1:0]  PORT_2      = 2'h2;
  localparam logic [1:0]  PORT_RSVD   = 2'h3;

  // drop reason codes
  typedef enum logic [3:0] {
    RSN_BCAST_LEVEL = 4'h0,
    RSN_RED         = 4'h1,
    RSN_NO_BUFFER   = 4'h2,
    RSN_NO_DESC     = 4'h3,
    RSN_NO_DEST     = 4'h4,
    RSN_RX_ERROR    = 4'h5,
    RSN_DROP_LEVEL  = 4'h6,
    RSN_YELLOW      = 4'h9
  } drop_reason_t;

  // one dropped packet as reported by the buffer manager, also a slot
  typedef struct packed {
    logic       valid;
    logic [1:0] port;
    logic [3:0] reason;
  } drop_event_t;

endpackage

// ---- logic/switch_drop_stats_irq.sv ----
// Purpose: per-port rate drop counters, drop capture slots and mask
// Assumes: classic wishbone slave, drop events come from mclk logic
// Notes:   one cycle answer, read side effects act on the ack edge
// Operation
// - per-port counter of rate-limit drops
// - counters reset zero, cleared by read
// - counter saturates at all ones
// - mask bit, set at reset, blocks interrupt
// - mask never blocks status capture
// - two capture slots A and B, B fills only while A is full
// - slot A valid bit0, reason 6:3, port 2:1
// - slot B pending bit7, reason 13:10, port 9:8
// - port codes 00,01,10; 11 never reported
// - reasons 0000 broadcast level, 0100 no destination
// - reasons 0001 red and 1001 yellow
// - reasons 0010 no buffer, 0011 no descriptor
// - reasons 0101 rx error, 0110 level; others reserved
// - pending fields reset zero, cleared by read
`timescale 1ns/100ps
module switch_drop_stats_irq
  import drop_stats_pkg::*;
#(
  parameter int NUM_PORTS = 3,
  parameter int CNT_W     = 32
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        cyc,
  input  wire logic        stb,
  input  wire logic        we,
  input  wire logic [15:0] adr,
  input  wire logic [3:0]  sel,
  input  wire logic [31:0] dat_w,
  output logic      [31:0] dat_r,
  output logic             ack,
  input  wire drop_event_t drop,
  output logic             irq_req
);

  logic [CNT_W-1:0] cnt      [NUM_PORTS];
  logic [CNT_W-1:0] next_cnt [NUM_PORTS];
  drop_event_t      slot_a;
  drop_event_t      slot_b;
  drop_event_t      next_slot_a;
  drop_event_t      next_slot_b;
  logic             mask;
  logic             next_mask;
  logic             next_ack;
  logic [31:0]      next_dat_r;
  logic             req;
  logic             rd;
  logic [13:0]      idx;
  logic             clr_pend;
  logic             ev_ok;
  logic             ev_rate;

  // only defined reasons may reach the status slots
  function automatic logic legal_reason(input logic [3:0] r);
    case (r)
      RSN_BCAST_LEVEL, RSN_NO_DEST:            legal_reason = 1'b1;
      RSN_RED, RSN_YELLOW:                     legal_reason = 1'b1;
      RSN_NO_BUFFER, RSN_NO_DESC:              legal_reason = 1'b1;
      RSN_RX_ERROR, RSN_DROP_LEVEL:            legal_reason = 1'b1;
      default:                                 legal_reason = 1'b0;
    endcase
  endfunction

  // counter step that sticks at the top
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    if (v == CNT_MAX[CNT_W-1:0]) begin
      sat_inc = v;
    end else begin
      sat_inc = v + 1'b1;
    end
  endfunction

  // pending word layout, fields above 13 read as zero
  function automatic logic [31:0] pack_pending(input drop_event_t a, input drop_event_t b);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[A_VALID_BIT]              = a.valid;
    w[A_PORT_LSB +: 2]          = a.port;
    w[A_RSN_LSB +: 4]           = a.reason;
    w[B_PEND_BIT]               = b.valid;
    w[B_PORT_LSB +: 2]          = b.port;
    w[B_RSN_LSB +: 4]           = b.reason;
    pack_pending = w;
  endfunction

  // bus decode, shared by both groups
  assign req      = cyc & stb & ~ack;
  assign rd       = req & ~we;
  assign idx      = adr[15:2];
  assign clr_pend = rd & (idx == IDX_PEND);
  // reserved port code is never captured nor counted
  assign ev_ok    = drop.valid & (drop.port != PORT_RSVD) & legal_reason(drop.reason);
  assign ev_rate  = ev_ok & ((drop.reason == RSN_RED) | (drop.reason == RSN_YELLOW));

  // bus answer and mask register
  always_comb begin
    next_ack   = req;
    next_mask  = mask;
    next_dat_r = 32'h0000_0000;
    if (req & we & (idx == IDX_MASK) & sel[0]) begin
      next_mask = dat_w[MASK_BIT];
    end
    if (rd) begin
      case (idx)
        IDX_CNT0: next_dat_r = 32'(cnt[0]);
        IDX_CNT1: next_dat_r = 32'(cnt[1]);
        IDX_CNT2: next_dat_r = 32'(cnt[2]);
        IDX_MASK: next_dat_r = {31'h0000_0000, mask};
        IDX_PEND: next_dat_r = pack_pending(slot_a, slot_b);
        default:  next_dat_r = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ack   <= 1'b0;
      dat_r <= 32'h0000_0000;
      mask  <= MASK_RESET;
    end else begin
      ack   <= next_ack;
      dat_r <= next_dat_r;
      mask  <= next_mask;
    end
  end

  // counters and slots; a drop in the clearing cycle survives the clear
  always_comb begin
    drop_event_t a;
    drop_event_t b;
    a = slot_a;
    b = slot_b;
    for (int p = 0; p < NUM_PORTS; p++) begin
      next_cnt[p] = cnt[p];
      if (rd & (idx == IDX_CNT0 + 14'(p))) begin
        next_cnt[p] = CNT_RESET[CNT_W-1:0];
      end
      if (ev_rate & (drop.port == 2'(p))) begin
        next_cnt[p] = sat_inc(next_cnt[p]);
      end
    end
    if (clr_pend) begin
      a = '0;
      b = '0;
    end
    // capture ignores the mask on purpose
    if (ev_ok & ~a.valid) begin
      a = drop;
    end else if (ev_ok & ~b.valid) begin
      b = drop;
    end
    next_slot_a = a;
    next_slot_b = b;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        cnt[p] <= CNT_RESET[CNT_W-1:0];
      end
      slot_a <= '0;
      slot_b <= '0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        cnt[p] <= next_cnt[p];
      end
      slot_a <= next_slot_a;
      slot_b <= next_slot_b;
    end
  end

  // request line, derived only from flops
  assign irq_req = (slot_a.valid | slot_b.valid) & ~mask;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_read_req;
    cyc & stb & ~we & ~ack;
  endsequence

  sequence s_answer;
    ##1 ack ##1 ~ack;
  endsequence

  a_bus_one_cycle: assert property (s_read_req |-> s_answer)
    else $error("wishbone ack not one cycle after request");

  // counters: one step per rate drop, a read empties them
  a_cnt_read_clear: assert property (
    rd & (idx == IDX_CNT0) & ~(ev_rate & (drop.port == PORT_0))
      |=> (cnt[0] == CNT_RESET) && (dat_r == $past(cnt[0])))
    else $error("port 0 counter not cleared by read");

  a_cnt1_read_clear: assert property (
    rd & (idx == IDX_CNT1) & ~(ev_rate & (drop.port == PORT_1))
      |=> (cnt[1] == CNT_RESET) && (dat_r == $past(cnt[1])))
    else $error("port 1 counter not cleared by read");

  a_cnt2_read_clear: assert property (
    rd & (idx == IDX_CNT2) & ~(ev_rate & (drop.port == PORT_2))
      |=> (cnt[2] == CNT_RESET) && (dat_r == $past(cnt[2])))
    else $error("port 2 counter not cleared by read");

  a_cnt_counts_up: assert property (
    ev_rate & (drop.port == PORT_1) & ~(rd & (idx == IDX_CNT1)) & (cnt[1] != CNT_MAX)
      |=> cnt[1] == $past(cnt[1]) + 1'b1)
    else $error("port 1 counter missed a drop");

  a_cnt0_counts_up: assert property (
    ev_rate & (drop.port == PORT_0) & ~(rd & (idx == IDX_CNT0)) & (cnt[0] != CNT_MAX)
      |=> cnt[0] == $past(cnt[0]) + 1'b1)
    else $error("port 0 counter missed a drop");

  a_cnt2_counts_up: assert property (
    ev_rate & (drop.port == PORT_2) & ~(rd & (idx == IDX_CNT2)) & (cnt[2] != CNT_MAX)
      |=> cnt[2] == $past(cnt[2]) + 1'b1)
    else $error("port 2 counter missed a drop");

  // anything else leaves every counter where it was
  a_cnt_other_hold: assert property (
    ~ev_rate & ~rd |=> $stable(cnt[0]) && $stable(cnt[1]) && $stable(cnt[2]))
    else $error("counter moved without a rate drop");

  // the top value is far beyond a run's reach, kept for formal use
  a_cnt_saturates: assert property (
    (cnt[2] == CNT_MAX) & ~(rd & (idx == IDX_CNT2)) |=> cnt[2] == CNT_MAX)
    else $error("port 2 counter left its maximum");

  // mask: moved only by a write with byte lane 0, gates just the line
  sequence s_write_req;
    cyc & stb & we & ~ack;
  endsequence

  a_bus_write_ack: assert property (s_write_req |-> s_answer)
    else $error("wishbone ack not one cycle after write");

  a_mask_write: assert property (
    req & we & (idx == IDX_MASK) & sel[0] |=> mask == $past(dat_w[MASK_BIT]))
    else $error("mask write did not land");

  a_mask_holds: assert property (
    ~(req & we & (idx == IDX_MASK) & sel[0]) |=> $stable(mask))
    else $error("mask changed without a write");

  a_mask_read: assert property (
    rd & (idx == IDX_MASK) |=> dat_r == {31'h0000_0000, $past(mask)})
    else $error("mask read back wrong");

  a_mask_blocks: assert property (mask |-> ~irq_req)
    else $error("interrupt raised while masked");

  a_irq_follows: assert property ((slot_a.valid | slot_b.valid) & ~mask |-> irq_req)
    else $error("interrupt missing with pending status");

  a_capture_masked: assert property (
    mask & ev_ok & ~slot_a.valid |=> slot_a.valid)
    else $error("masked drop not captured");

  // slots: A fills first, then B; full slots refuse further drops
  a_slot_a_fill: assert property (
    ev_ok & ~slot_a.valid & ~clr_pend
      |=> slot_a.valid && (slot_a.port == $past(drop.port)) && (slot_a.reason == $past(drop.reason)))
    else $error("free slot A did not capture drop");

  a_slot_b_fill: assert property (
    ev_ok & slot_a.valid & ~slot_b.valid & ~clr_pend |=> slot_b.valid && $stable(slot_a))
    else $error("slot B did not capture second drop");

  a_slots_full_hold: assert property (
    slot_a.valid & slot_b.valid & ~clr_pend |=> $stable(slot_a) && $stable(slot_b))
    else $error("full slots overwritten by a drop");

  a_b_after_a: assert property (slot_b.valid |-> slot_a.valid)
    else $error("slot B filled while slot A empty");

  // an empty slot reads as all zero, so stale fields never show
  a_empty_a_zero: assert property (~slot_a.valid |-> slot_a == 7'h00)
    else $error("empty slot A holds stale fields");

  a_empty_b_zero: assert property (~slot_b.valid |-> slot_b == 7'h00)
    else $error("empty slot B holds stale fields");

  a_pend_clear: assert property (
    clr_pend & ~ev_ok |=> ~slot_a.valid && ~slot_b.valid
      && (dat_r == pack_pending($past(slot_a), $past(slot_b))))
    else $error("pending status not cleared by read");

  a_pend_high_zero: assert property (
    rd & (idx == IDX_PEND) |=> dat_r[31:14] == 18'h00000)
    else $error("pending read shows reserved bits");

  a_port_legal: assert property (slot_a.valid |-> slot_a.port != PORT_RSVD)
    else $error("reserved port code captured");

  a_port_b_legal: assert property (slot_b.valid |-> slot_b.port != PORT_RSVD)
    else $error("reserved port code captured in slot B");

  // reserved reason codes must never reach a slot
  a_reason_a_legal: assert property (slot_a.valid |-> legal_reason(slot_a.reason))
    else $error("reserved reason captured in slot A");

  a_reason_b_legal: assert property (slot_b.valid |-> legal_reason(slot_b.reason))
    else $error("reserved reason captured in slot B");

endmodule

// ---- test/switch_drop_stats_irq_tb.sv ----
// Purpose: self-checking bench for drop counters, slots and mask
// Assumes: wishbone single cycles, one answer per request
// Notes:   integer model, compared at every read and every cycle
`timescale 1ns/100ps
module switch_drop_stats_irq_tb;
  import drop_stats_pkg::*;
  localparam logic [13:0] IDX_LIST [6] = '{IDX_CNT0, IDX_CNT1, IDX_CNT2, IDX_MASK, IDX_PEND, 14'h1c19};
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [15:0] adr = 16'h0;
  logic [3:0]  sel = 4'hf;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_r;
  logic        ack;
  drop_event_t drop = '0;
  logic        irq_req;
  logic [31:0] q;
  logic [31:0] q_exp;
  logic [31:0] cnt [3] = '{0, 0, 0};
  logic [6:0]  slot_a = 7'h0;
  logic [6:0]  slot_b = 7'h0;
  logic        mask_m = 1'b1;
  int          mismatches = 0;
  int          compares = 0;
  int          cycles = 0;

  switch_drop_stats_irq u_switch_drop_stats_irq (.mclk(mclk), .rstn(rstn), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .sel(sel), .dat_w(dat_w), .dat_r(dat_r), .ack(ack), .drop(drop), .irq_req(irq_req));

  always #4 mclk = ~mclk;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // model read, clearing counters and slots as the register does
  function automatic logic [31:0] model_read(input logic [13:0] idx);
    logic [31:0] v;
    v = 32'h0;
    if (idx >= IDX_CNT0 && idx <= IDX_CNT2) begin
      v = cnt[idx - IDX_CNT0];
      cnt[idx - IDX_CNT0] = 32'h0;
    end
    if (idx == IDX_MASK) v = {31'h0, mask_m};
    if (idx == IDX_PEND) begin
      v = {18'h0, slot_b, slot_a};
      slot_a = 7'h0;
      slot_b = 7'h0;
    end
    return v;
  endfunction

  // one classic cycle; held until ack is sampled high
  task automatic bus(input logic w, input logic [13:0] idx, input logic [31:0] d, input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= s;
    dat_w <= d;
    // the design acts on the request at its first edge, so the model does too
    @(posedge mclk);
    q_exp = 32'h0;
    if (w && idx == IDX_MASK && s[0]) mask_m = d[0];
    if (!w) q_exp = model_read(idx);
    while (ack !== 1'b1) @(posedge mclk);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic check_all();
    foreach (IDX_LIST[i]) begin
      bus(1'b0, IDX_LIST[i], 32'h0, 4'hf);
      chk("register read", q, q_exp);
    end
  endtask

  // one drop event, held for one edge, then a quiet cycle
  task automatic ev(input logic [1:0] p, input logic [3:0] r);
    drop <= '{valid: 1'b1, port: p, reason: r};
    @(posedge mclk);
    drop <= '0;
    if (p != PORT_RSVD && r inside {[4'h0:4'h6], 4'h9}) begin
      if ((r == RSN_RED || r == RSN_YELLOW) && cnt[p] != CNT_MAX) cnt[p] = cnt[p] + 1;
      if (slot_a == 7'h0) slot_a = {r, p, 1'b1};
      else if (slot_b == 7'h0) slot_b = {r, p, 1'b1};
    end
    @(posedge mclk);
  endtask

  // irq follows slots and mask; flops settled at the falling edge
  always @(negedge mclk) begin
    if (rstn) chk("irq_req", {31'h0, irq_req}, {31'h0, (slot_a != 7'h0 || slot_b != 7'h0) && !mask_m});
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      final_report();
    end
  end

  initial begin
    logic [13:0] idx;
    logic [31:0] d;
    void'($urandom(32'h4e625a6e));
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    check_all();
    // every reason code on a legal port, masked slots still record
    for (int r = 0; r < 16; r++) begin
      ev(2'(r % 3), 4'(r));
      if (r % 3 == 2) check_all();
    end
    // random traffic, mask changes and ignored writes
    for (int k = 0; k < 60; k++) begin
      idx = IDX_LIST[$urandom % 6];
      d = $urandom;
      bus(1'b1, idx, d, 4'($urandom));
      repeat ($urandom % 5) ev(2'($urandom), 4'($urandom));
      repeat ($urandom % 3) @(posedge mclk);
      if (k % 2) check_all();
    end
    check_all();
    // reset in mid-run with counts, status and a clear mask standing
    bus(1'b1, IDX_MASK, 32'h0, 4'hf);
    ev(PORT_1, RSN_RED);
    ev(PORT_2, RSN_YELLOW);
    rstn <= 1'b0;
    cnt = '{32'h0, 32'h0, 32'h0};
    slot_a = 7'h0;
    slot_b = 7'h0;
    mask_m = 1'b1;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    check_all();
    final_report();
  end
endmodule
